// File: bench/core_test_slave_interface_test.sv
`timescale 1ns/1ps
// ***********************************************************
// Testbench for the core test slave
// ***********************************************************
module core_test_slave_interface_test;

   logic clk;
   logic sys_rst;
   logic test_mode_pin;
   logic sel, act, wr, rdy;
   logic [31:0] wdata;
   logic [31:0] read_data;
   logic ready_out;
   logic [1:0] resp;
   logic ext_fiq, ext_irq, ext_rst, fault, mclk_en;
   logic [31:0] core_data, core_addr;
   cts_pkg::cts_core_status_t core_status;
   logic de_low, dei_low;
   cts_pkg::cts_core_ctrl_t core_ctrl;
   logic mem_clk, strobe;
   logic [31:0] bare_rdata;
   cts_pkg::cts_core_ctrl_t bare_ctrl;
   logic bare_strobe;
   logic [27:0] vec;
   int fail_count;
   int n_tests;

   // Bus master model
   cts_test_ctrl_model tester (
      .clk(clk), .slave_select(sel), .slave_trans_active(act),
      .slave_write(wr), .slave_ready_in(rdy), .slave_write_data(wdata)
   );

   cts_test_slave DUT (
      .clk(clk), .sys_rst(sys_rst), .test_mode_pin(test_mode_pin),
      .slave_select(sel), .slave_trans_active(act), .slave_write(wr),
      .slave_ready_in(rdy), .slave_write_data(wdata),
      .slave_read_data(read_data), .slave_ready_out(ready_out),
      .slave_response(resp), .ext_fast_interrupt_low(ext_fiq),
      .ext_interrupt_low(ext_irq), .ext_core_reset_low(ext_rst),
      .internal_fault_indication(fault), .master_clock_enable(mclk_en),
      .core_data_out(core_data), .core_address(core_addr),
      .core_status(core_status), .data_out_enable_low(de_low),
      .data_out_enable_internal_low(dei_low), .core_ctrl(core_ctrl),
      .core_mem_clock(mem_clk), .test_strobe_clock(strobe)
   );

   // Same slave with the test logic left out
   cts_test_slave #(.TEST_PRESENT(1'b0)) bare_dut (
      .clk(clk), .sys_rst(sys_rst), .test_mode_pin(test_mode_pin),
      .slave_select(sel), .slave_trans_active(act), .slave_write(wr),
      .slave_ready_in(rdy), .slave_write_data(wdata),
      .slave_read_data(bare_rdata), .slave_ready_out(),
      .slave_response(), .ext_fast_interrupt_low(ext_fiq),
      .ext_interrupt_low(ext_irq), .ext_core_reset_low(ext_rst),
      .internal_fault_indication(fault), .master_clock_enable(mclk_en),
      .core_data_out(core_data), .core_address(core_addr),
      .core_status(core_status), .data_out_enable_low(de_low),
      .data_out_enable_internal_low(dei_low), .core_ctrl(bare_ctrl),
      .core_mem_clock(), .test_strobe_clock(bare_strobe)
   );

   // Free running bus clock, 20 ns period
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                        input string what);
      n_tests++;
      if (seen !== exp) begin
         fail_count++;
         $display("MISMATCH at %0t: %s seen %h expected %h", $time, what,
                  seen, exp);
      end
   endtask

   task automatic final_report();
      $display("Checks %0d, mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // Fixed slave answers, looked at in the idle, data and turnaround states
   task automatic check_slave();
      check(ready_out, cts_pkg::RESP_READY, "ready");
      check(resp, cts_pkg::RESP_OKAY, "response");
   endtask

   // Normal mode levels and pass-through
   task automatic check_normal();
      cts_pkg::cts_core_ctrl_t exp;
      exp = {cts_pkg::BUS_DRIVE_DEFAULT, ext_fiq, ext_irq, fault, 1'b1,
             ext_rst, cts_pkg::BUS_MODE_DEFAULT,
             cts_pkg::DIN_EN_LOW_DEFAULT};
      check(core_ctrl, exp, "normal ctrl");
      check(read_data, cts_pkg::RDATA_IDLE, "idle rdata");
      check(strobe, 1'b0, "idle strobe");
      check_slave();
   endtask

   // Full test vector sequence; direction picks data in or readout
   task automatic run_vector(input logic dir, input logic [5:0] low,
                             input logic err, input logic [29:0] st);
      logic [31:0] exp;
      vec = tester.make_vec(low, err);
      exp = {st[29:16], st[3], st[8], st[15:0]};
      // Core lines move on the falling edge that opens the vector
      fork
         begin
            @(negedge clk);
            core_status = st;
            de_low = st[3];
            dei_low = st[8];
         end
      join_none
      tester.step(1'b1, 1'b1, 1'b1, 32'h00000000);
      check(strobe, 1'b0, "ctrl in strobe");
      tester.step(1'b1, dir, 1'b1, {4'h0, vec});
      check(strobe, 1'b1, "data strobe");
      check(core_ctrl[7:5], vec[5:3], "vector 5..3");
      check(core_ctrl.core_abort, vec[2], "abort");
      check(core_ctrl.core_stall_low, vec[1], "stall");
      check(core_ctrl.core_reset_low, vec[0], "reset low");
      if (!dir) begin
         check(read_data, core_data, "data out");
      end else begin
         check(read_data, cts_pkg::RDATA_IDLE, "data in zero");
      end
      check(bare_strobe, 1'b0, "bare strobe");
      check(bare_ctrl.core_stall_low, 1'b1, "bare stall");
      check(bare_rdata, cts_pkg::RDATA_IDLE, "bare rdata");
      check_slave();
      tester.step(1'b1, 1'b1, 1'b1, 32'h00000000);
      check(tester.mask_status(read_data), tester.mask_status(exp),
            "status");
      check(core_ctrl.core_stall_low, 1'b0, "stall gated");
      // Enables move mid-cycle after the strobe; readback keeps the capture
      fork
         begin
            @(negedge clk);
            de_low = ~de_low;
            dei_low = ~dei_low;
            #2;
            check(read_data[17:16], exp[17:16],
                  "captured enables");
         end
      join_none
      tester.step(1'b1, 1'b1, 1'b1, 32'h00000000);
      check(read_data, core_addr, "address out");
      check(mem_clk, 1'b1, "no clock in address");
      tester.step(1'b1, 1'b1, 1'b1, 32'h00000000);
      check(read_data, 32'h00000000, "turnaround zero");
      check(mem_clk, 1'b1, "no clock in turnaround");
      check_slave();
   endtask

   // Main sequence
   initial begin
      sys_rst = 1'b1;
      test_mode_pin = 1'b0;
      ext_fiq = 1'b1;
      ext_irq = 1'b1;
      ext_rst = 1'b1;
      fault = 1'b0;
      mclk_en = 1'b1;
      core_data = 32'h5a3c96e1;
      core_addr = 32'h0ff0a55c;
      core_status = 30'h00000000;
      de_low = 1'b1;
      dei_low = 1'b1;
      vec = 28'h0000000;
      fail_count = 0;
      n_tests = 0;
      repeat (12) @(posedge clk);
      @(negedge clk);
      sys_rst = 1'b0;
      tester.step(1'b0, 1'b0, 1'b1, 32'h00000000);
      // Normal mode pass-through, both levels of every input
      for (int i = 0; i < 2; i++) begin
         @(negedge clk);
         ext_fiq = i[0];
         ext_irq = ~i[0];
         ext_rst = i[0];
         fault = ~i[0];
         @(posedge clk);
         #2;
         check_normal();
      end
      // Memory clock runs outside test, stops on a low enable
      check(mem_clk, 1'b0, "free clock high phase");
      @(negedge clk);
      #2;
      check(mem_clk, 1'b1, "free clock low phase");
      mclk_en = 1'b0;
      @(posedge clk);
      #2;
      check(mem_clk, 1'b1, "latched enable off");
      @(negedge clk);
      mclk_en = 1'b1;
      // Enter test mode; unselected and stalled cycles do not advance
      test_mode_pin = 1'b1;
      repeat (3) tester.step(1'b0, 1'b0, 1'b1, 32'h00000000);
      tester.step(1'b0, 1'b1, 1'b1, 32'h00000000);
      check(strobe, 1'b0, "unselected");
      tester.step(1'b1, 1'b1, 1'b0, 32'h00000000);
      tester.step(1'b1, 1'b1, 1'b0, 32'h00000000);
      check(strobe, 1'b0, "not taken");
      // Back to back sequences over both directions and edge vectors
      run_vector(1'b1, 6'h2a, 1'b0, 30'h2d3c96a5);
      run_vector(1'b0, 6'h15, 1'b1, 30'h12c3695a);
      run_vector(1'b0, 6'h3f, 1'b0, 30'h3fffffff);
      run_vector(1'b1, 6'h00, 1'b0, 30'h00000000);
      // Reset in mid sequence returns to normal clocking
      tester.step(1'b1, 1'b1, 1'b1, 32'h00000000);
      tester.step(1'b1, 1'b1, 1'b1, 32'h00000000);
      @(negedge clk);
      sys_rst = 1'b1;
      @(posedge clk);
      #2;
      check_normal();
      @(negedge clk);
      sys_rst = 1'b0;
      // Leaving test mode ignores further transfers
      test_mode_pin = 1'b0;
      repeat (3) tester.step(1'b1, 1'b1, 1'b1, 32'h00000000);
      check_normal();
      final_report();
   end

endmodule

// File: bench/cts_tic_model.sv
`timescale 1ns/1ps
// ***********************************************************
// External test controller, bus master side
// ***********************************************************
module cts_test_ctrl_model (
   // Clock
   input wire logic clk,
   // Slave bus driven by the controller
   output logic slave_select,
   output logic slave_trans_active,
   output logic slave_write,
   output logic slave_ready_in,
   output logic [31:0] slave_write_data
);

   // Idle bus at time zero
   initial begin
      slave_select = 1'b0;
      slave_trans_active = 1'b0;
      slave_write = 1'b0;
      slave_ready_in = 1'b1;
      slave_write_data = 32'h00000000;
   end

   // One bus cycle: change after the falling edge, hold over the sample
   task automatic step(input logic sel, input logic wr, input logic rdy,
                       input logic [31:0] wd);
      @(negedge clk);
      slave_select = sel;
      slave_trans_active = sel;
      slave_write = wr;
      slave_ready_in = rdy;
      // Released data lines never keep the last value
      slave_write_data = sel ? wd : ~slave_write_data;
      @(posedge clk);
      #2;
   endtask

   function automatic logic [27:0] make_vec(input logic [5:0] low,
                                            input logic bus_err);
      make_vec = {22'h000000, low} | {25'h0000000, bus_err, 2'h0};
   endfunction

   // mask test output
   // Bit 18 floats whenever the test output driver is off
   function automatic logic [31:0] mask_status(input logic [31:0] w);
      mask_status = w & 32'hfffbffff;
   endfunction

endmodule

// File: logic/cts_pkg.sv
package cts_pkg;

   // ***********************************************************
   // Control vector layout
   // ***********************************************************
   localparam int VEC_WIDTH = 28;
   localparam int VEC_DRIVE_BIT = 5;
   localparam int VEC_FIQ_BIT = 4;
   localparam int VEC_IRQ_BIT = 3;
   localparam int VEC_ABORT_BIT = 2;
   localparam int VEC_STALL_BIT = 1;
   localparam int VEC_RESET_BIT = 0;
   localparam logic [27:0] VEC_RESET_VAL = 28'h0000023;

   // ***********************************************************
   // Slave answers and fixed core levels
   // ***********************************************************
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic RESP_READY = 1'h1;
   localparam logic BUS_DRIVE_DEFAULT = 1'h1;
   localparam logic BUS_MODE_DEFAULT = 1'h0;
   localparam logic DIN_EN_LOW_DEFAULT = 1'h0;
   localparam logic [31:0] RDATA_IDLE = 32'h00000000;

   // ***********************************************************
   // Types
   // ***********************************************************
   typedef enum logic [2:0] {
      ST_INACTIVE,
      ST_CTRL_IN,
      ST_DATA_IN,
      ST_DATA_READOUT,
      ST_STATUS_READOUT,
      ST_ADDRESS_READOUT,
      ST_TURNAROUND
   } cts_state_t;

   // Core status lines in readback order, bits 17:16 excluded
   typedef struct packed {
      logic bus_disable_flag;
      logic [3:0] scan_chain_select;
      logic tap_float_instruction;
      logic test_out_drive_low;
      logic internal_debug_request;
      logic watchpoint_match_0;
      logic watchpoint_match_1;
      logic comms_receive_flag;
      logic comms_transmit_flag;
      logic debug_acknowledge;
      logic test_data_out;
      logic compressed_state_flag;
      logic coprocessor_instr_low;
      logic [4:0] processor_mode_inverted;
      logic memory_translate_low;
      logic not_executed_flag;
      logic locked_operation;
      logic [1:0] access_size;
      logic opcode_fetch_low;
      logic read_write_low;
      logic memory_request_low;
      logic sequential_address_flag;
   } cts_core_status_t;

   // Core control inputs driven by this block
   typedef struct packed {
      logic data_bus_drive_enable;
      logic fast_interrupt_low;
      logic interrupt_low;
      logic core_abort;
      logic core_stall_low;
      logic core_reset_low;
      logic bus_mode_select;
      logic data_in_enable_low;
   } cts_core_ctrl_t;

endpackage

// File: logic/cts_test_slave.sv
`timescale 1ns/1ps
// Operation
// - Vector bits 5..3 drive bus, fiq, irq.
// - Stall bit ANDed with strobe; bit0 resets.
// - Readout states select data, address, status.
// - Status 31..25: disable, scan, float, tdo-en.
// - Status 24..18: debug, ranges, comms, ack, tdo.
// - Bits 17,16 captured on test strobe.
// - Status 15..9,7: compressed, cp, mode, executed.
// - Status 8,6..0: translate, lock, size, access.
// - Slave outputs only matter in test.
// - Slave ready always high.
// - Slave response always okay.
// - Read data: core data, address, status, or zero.
// - Normal mode: defaults or passed-through inputs.
// - Normal abort comes from fault indication.
// - Bus mode, data-in enable tied constant.
// - Without test logic, outputs stay in normal mode.
// - Clock enables built on inverted bus clock.
// - Memory clock is NAND of clock, enable.
// - Delayed enable held by set latch.
// - Vector enable on selected active transfer.
// - Core not clocked during status/address readout.
module cts_test_slave #(
   parameter bit TEST_PRESENT = 1'b1
) (
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Test mode pin
   input wire logic test_mode_pin,
   // Slave bus
   input wire logic slave_select,
   input wire logic slave_trans_active,
   input wire logic slave_write,
   input wire logic slave_ready_in,
   input wire logic [31:0] slave_write_data,
   output logic [31:0] slave_read_data,
   output logic slave_ready_out,
   output logic [1:0] slave_response,
   // Wrapper inputs passed to the core in normal mode
   input wire logic ext_fast_interrupt_low,
   input wire logic ext_interrupt_low,
   input wire logic ext_core_reset_low,
   input wire logic internal_fault_indication,
   input wire logic master_clock_enable,
   // Core outputs
   input wire logic [31:0] core_data_out,
   input wire logic [31:0] core_address,
   input wire cts_pkg::cts_core_status_t core_status,
   input wire logic data_out_enable_low,
   input wire logic data_out_enable_internal_low,
   // Core inputs
   output cts_pkg::cts_core_ctrl_t core_ctrl,
   output logic core_mem_clock,
   output logic test_strobe_clock
);

   // ***********************************************************
   // Test mode pin synchroniser
   // ***********************************************************
   logic mode_meta_reg;
   logic mode_sync_reg;
   logic test_mode;

   // Pin is asynchronous to the bus clock
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         mode_meta_reg <= 1'b0;
         mode_sync_reg <= 1'b0;
      end else begin
         mode_meta_reg <= test_mode_pin;
         mode_sync_reg <= mode_meta_reg;
      end
   end

   // Removed test logic leaves the wrapper permanently in normal mode
   // static mode select
   assign test_mode = TEST_PRESENT & mode_sync_reg;

   // ***********************************************************
   // Test sequencer
   // ***********************************************************
   cts_pkg::cts_state_t state_reg;
   cts_pkg::cts_state_t state_next;
   logic test_vector_enable;
   logic xfer_done;
   logic [27:0] vector_reg;

   assign test_vector_enable = test_mode & slave_select & slave_trans_active;
   // Data phase completes when the bus is ready
   assign xfer_done = slave_ready_in;

   // Next state follows the fixed vector sequence
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         cts_pkg::ST_INACTIVE: begin
            if (test_vector_enable) begin
               state_next = cts_pkg::ST_CTRL_IN;
            end
         end
         cts_pkg::ST_CTRL_IN: begin
            if (test_vector_enable) begin
               state_next = slave_write ? cts_pkg::ST_DATA_IN
                                        : cts_pkg::ST_DATA_READOUT;
            end
         end
         cts_pkg::ST_DATA_IN, cts_pkg::ST_DATA_READOUT: begin
            if (test_vector_enable) begin
               state_next = cts_pkg::ST_STATUS_READOUT;
            end
         end
         cts_pkg::ST_STATUS_READOUT: begin
            if (test_vector_enable) begin
               state_next = cts_pkg::ST_ADDRESS_READOUT;
            end
         end
         cts_pkg::ST_ADDRESS_READOUT: begin
            if (test_vector_enable) begin
               state_next = cts_pkg::ST_TURNAROUND;
            end
         end
         cts_pkg::ST_TURNAROUND: begin
            if (test_vector_enable) begin
               state_next = cts_pkg::ST_CTRL_IN;
            end
         end
         default: begin
            state_next = cts_pkg::ST_INACTIVE;
         end
      endcase
   end

   // Advance only when the previous data phase has finished
   // reset to inactive
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state_reg <= cts_pkg::ST_INACTIVE;
      end else if (!test_mode) begin
         state_reg <= cts_pkg::ST_INACTIVE;
      end else if (xfer_done) begin
         state_reg <= state_next;
      end
   end

   // Vector is loaded from write data in the control data phase
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         vector_reg <= cts_pkg::VEC_RESET_VAL;
      end else if (state_reg == cts_pkg::ST_CTRL_IN && xfer_done) begin
         vector_reg <= slave_write_data[cts_pkg::VEC_WIDTH-1:0];
      end
   end

   // Core steps only in the data access cycles
   // no core clock during status or address readout
   assign test_strobe_clock = (state_reg == cts_pkg::ST_DATA_IN) |
                              (state_reg == cts_pkg::ST_DATA_READOUT);

   // ***********************************************************
   // Status capture and read data
   // ***********************************************************
   logic enout_reg;
   logic enouti_reg;
   logic [31:0] status_word;

   // Enables are valid only in the data cycle, so hold them after
   // capture on strobe
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         enout_reg <= 1'b1;
         enouti_reg <= 1'b1;
      end else if (test_strobe_clock) begin
         enout_reg <= data_out_enable_low;
         enouti_reg <= data_out_enable_internal_low;
      end
   end

   // Bit 18 (tdo) is passed raw; the tester masks it when floating
   // top status bits
   assign status_word = {core_status[29:16], enout_reg, enouti_reg,
                         core_status[15:0]};

   // Readout selection by current test state
   // readout multiplexer
   always_comb begin
      slave_read_data = cts_pkg::RDATA_IDLE;
      if (test_mode) begin
         case (state_reg)
            cts_pkg::ST_DATA_READOUT: slave_read_data = core_data_out;
            cts_pkg::ST_ADDRESS_READOUT: slave_read_data = core_address;
            cts_pkg::ST_STATUS_READOUT: slave_read_data = status_word;
            default: slave_read_data = cts_pkg::RDATA_IDLE;
         endcase
      end
   end

   assign slave_ready_out = cts_pkg::RESP_READY;
   assign slave_response = cts_pkg::RESP_OKAY;

   // ***********************************************************
   // Control input multiplexer
   // ***********************************************************
   logic in_test;

   assign in_test = test_mode & (state_reg != cts_pkg::ST_INACTIVE);

   // Test vector drives the core only while a test is under way
   always_comb begin
      core_ctrl.bus_mode_select = cts_pkg::BUS_MODE_DEFAULT;
      core_ctrl.data_in_enable_low = cts_pkg::DIN_EN_LOW_DEFAULT;
      if (in_test) begin
         core_ctrl.data_bus_drive_enable = vector_reg[cts_pkg::VEC_DRIVE_BIT];
         core_ctrl.fast_interrupt_low = vector_reg[cts_pkg::VEC_FIQ_BIT];
         core_ctrl.interrupt_low = vector_reg[cts_pkg::VEC_IRQ_BIT];
         core_ctrl.core_abort = vector_reg[cts_pkg::VEC_ABORT_BIT];
         core_ctrl.core_stall_low = vector_reg[cts_pkg::VEC_STALL_BIT] &
                                    test_strobe_clock;
         core_ctrl.core_reset_low = vector_reg[cts_pkg::VEC_RESET_BIT];
      end else begin
         core_ctrl.data_bus_drive_enable = cts_pkg::BUS_DRIVE_DEFAULT;
         core_ctrl.fast_interrupt_low = ext_fast_interrupt_low;
         core_ctrl.interrupt_low = ext_interrupt_low;
         core_ctrl.core_abort = internal_fault_indication;
         core_ctrl.core_stall_low = 1'b1;
         core_ctrl.core_reset_low = ext_core_reset_low;
      end
   end

   // ***********************************************************
   // Memory clock gating
   // ***********************************************************
   logic inverted_bus_clock;
   logic delayed_clock_enable;
   logic test_clock_enable_term;
   logic latch_in;

   // Inverted clock opens the enable latch and clocks the rising-edge test term
   // inverted clock source
   assign inverted_bus_clock = ~clk;
   assign latch_in = test_mode ? 1'b1 : master_clock_enable;

   // Transparent while the bus clock is low, so the enable is steady
   // through the low pulse of the gated clock
   // latch with set
   always_latch begin
      if (sys_rst) begin
         delayed_clock_enable = 1'b1;
      end else if (inverted_bus_clock) begin
         delayed_clock_enable = latch_in;
      end
   end

   // Test term changes mid-cycle, away from the gated edge
   // test enable term
   always_ff @(posedge inverted_bus_clock) begin
      if (sys_rst) begin
         test_clock_enable_term <= 1'b1;
      end else begin
         test_clock_enable_term <= !test_mode | test_strobe_clock;
      end
   end

   // Low pulse each enabled cycle; inactive level is high
   // clock nand
   assign core_mem_clock = ~(clk & delayed_clock_enable &
                             test_clock_enable_term);

   // ***********************************************************
   // Checks
   // ***********************************************************
   ready_always_high_a:
   assert property (@(posedge clk) disable iff (sys_rst)
      slave_ready_out == 1'b1)
      else $error("slave ready dropped");

   resp_always_okay_a:
   assert property (@(posedge clk) disable iff (sys_rst)
      slave_response == cts_pkg::RESP_OKAY)
      else $error("slave response not okay");

   vector_load_a:
   assert property (@(posedge clk) disable iff (sys_rst)
      (state_reg == cts_pkg::ST_CTRL_IN && xfer_done && test_mode
       ##1 in_test) |->
      core_ctrl.interrupt_low == $past(slave_write_data[3]) &&
      core_ctrl.fast_interrupt_low == $past(slave_write_data[4]))
      else $error("vector bits not on core inputs");

   stall_gate_a:
   assert property (@(posedge clk) disable iff (sys_rst)
      (in_test && !test_strobe_clock) |-> !core_ctrl.core_stall_low)
      else $error("stall released outside data cycle");

   status_readout_a:
   assert property (@(posedge clk) disable iff (sys_rst)
      state_reg == cts_pkg::ST_STATUS_READOUT |->
      slave_read_data[31] == core_status.bus_disable_flag &&
      slave_read_data[0] == core_status.sequential_address_flag)
      else $error("status word misplaced");

   idle_read_zero_a:
   assert property (@(posedge clk) disable iff (sys_rst)
      !test_mode |-> slave_read_data == cts_pkg::RDATA_IDLE)
      else $error("read data not zero outside test");

   enable_capture_a:
   assert property (@(posedge clk) disable iff (sys_rst)
      (test_strobe_clock ##1 !test_strobe_clock) |->
      enout_reg == $past(data_out_enable_low))
      else $error("enable output not captured");

   normal_abort_a:
   assert property (@(posedge clk) disable iff (sys_rst)
      !in_test |-> core_ctrl.core_abort == internal_fault_indication)
      else $error("abort not from fault indication");

   readout_no_clock_a:
   assert property (@(posedge clk) disable iff (sys_rst)
      (state_reg == cts_pkg::ST_STATUS_READOUT ||
       state_reg == cts_pkg::ST_ADDRESS_READOUT) |=>
      !test_clock_enable_term || !$past(test_mode))
      else $error("core clocked during readout");

   reset_inactive_a:
   assert property (@(posedge clk)
      $past(sys_rst) |-> state_reg == cts_pkg::ST_INACTIVE)
      else $error("state not inactive after reset");

endmodule
